//--- hw/config_port_map.vh
// Constants for the configuration port: addresses, register map, fields, resets
`ifndef CONFIG_PORT_MAP_VH
`define CONFIG_PORT_MAP_VH
// Seven-bit bus addresses by address select pin state
`define ADDR_FLOAT 7'h66
`define ADDR_GND 7'h65
`define ADDR_VDD 7'h67
// Address select pin decode codes
`define SEL_GND 2'b00
`define SEL_FLOAT 2'b01
`define SEL_VDD 2'b10
// Register offsets
`define REG_INPUT_STATUS 8'h00
`define REG_DEVICE_CONTROL 8'h05
`define REG_TRIM_LO 8'h18
`define REG_TRIM_HI 8'h19
// Device control fields and reset
`define CTRL_MODE_HI 4
`define CTRL_MODE_LO 3
`define CTRL_FALLBACK 2
`define CTRL_RESET 8'h2B
// Primary loop mode codes
`define MODE_FREE_RUN 2'b00
`define MODE_GENLOCK 2'b01
`define MODE_HOLDOVER 2'b10
// Trim register resets
`define TRIM_LO_RESET 8'h00
`define TRIM_HI_RESET 8'h80
// Reference clock alive window, in system clock cycles
`define REF_ALIVE_CYCLES 8'h10
`endif

//--- hw/config_port.v
// I2C configuration target with loop mode selection and input reference status
`timescale 1ns/1ps
`include "config_port_map.vh"
module config_port #(
  parameter CTRL_W = 16
)(
  input wire clock, // System clock, 25 MHz
  input wire nrst, // Asynchronous reset, active low
  input wire scl_in, // Bus clock pin
  input wire sda_in, // Bus data pin level
  output reg sda_oe_n, // Data pin enable, low drives low
  input wire [1:0] addr_sel, // Decoded three-state address pin
  input wire ref_clk_27, // 27 MHz reference clock pin
  input wire hsync_in, // Horizontal sync input
  input wire vsync_in, // Vertical sync input
  input wire field_in, // Field sync input
  input wire ref_loss_pin, // Level of loss-of-reference output pin
  input wire det_interlaced, // Detector: interlaced format
  input wire det_analog, // Detector: analog-derived reference
  input wire det_polarity, // Detector: hsync polarity
  input wire det_hdv_warn, // Detector: missing-h warning pending
  input wire det_h_only, // Detector: horizontal-only sync
  input wire hsync_absent, // Detector: horizontal sync missing
  input wire [CTRL_W-1:0] loop_error, // Phase error from genlock detector
  output reg [CTRL_W-1:0] osc_level, // Oscillator control level
  output reg [1:0] primary_loop_mode, // Mode field value
  output reg ref_loss_fallback, // Fallback selection
  output reg holdover_active, // Held control level in use
  output reg secondary_follow // Secondary loops track the primary
);

  // ************************************
  // Input synchronisers
  // ************************************
  reg [1:0] scl_s_reg, sda_s_reg, ref_s_reg;
  reg [1:0] ld_s_reg;
  reg [7:0] st_s_reg;
  reg [7:0] st_s2_reg;
  reg [1:0] sel_s_reg, sel_s2_reg;
  reg scl_d_reg, sda_d_reg, ref_d_reg;

  // Two stages on every pin except field_in and loop_error; only second stages are read below
  always @(posedge clock or negedge nrst)
    if (!nrst)
    begin
      scl_s_reg <= 2'b11;
      sda_s_reg <= 2'b11;
      ref_s_reg <= 2'b00;
      ld_s_reg <= 2'b00;
      st_s_reg <= 8'h00;
      st_s2_reg <= 8'h00;
      sel_s_reg <= `SEL_FLOAT;
      sel_s2_reg <= `SEL_FLOAT;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      ref_d_reg <= 1'b0;
    end
    else
    begin
      scl_s_reg <= {scl_s_reg[0], scl_in};
      sda_s_reg <= {sda_s_reg[0], sda_in};
      ref_s_reg <= {ref_s_reg[0], ref_clk_27};
      ld_s_reg <= {ld_s_reg[0], ref_loss_pin};
      st_s_reg <= {det_interlaced, det_analog, det_polarity, det_hdv_warn,
        det_h_only, hsync_absent, hsync_in, vsync_in};
      st_s2_reg <= st_s_reg;
      sel_s_reg <= addr_sel;
      sel_s2_reg <= sel_s_reg;
      scl_d_reg <= scl_s_reg[1];
      sda_d_reg <= sda_s_reg[1];
      ref_d_reg <= ref_s_reg[1];
    end

  wire scl = scl_s_reg[1];
  wire sda = sda_s_reg[1];
  wire scl_rise = scl & ~scl_d_reg;
  wire scl_fall = ~scl & scl_d_reg;
  wire start_cond = scl & scl_d_reg & sda_d_reg & ~sda;
  wire stop_cond = scl & scl_d_reg & ~sda_d_reg & sda;

  // ************************************
  // Reference clock watchdog
  // ************************************
  reg [7:0] alive_cnt_reg;
  wire ref_alive = (alive_cnt_reg != 8'h00);

  // Any sampled edge of the 27 MHz clock rearms the window
  always @(posedge clock or negedge nrst)
    if (!nrst)
      alive_cnt_reg <= 8'h00;
    else if (ref_s_reg[1] != ref_d_reg)
      alive_cnt_reg <= `REF_ALIVE_CYCLES;
    else if (ref_alive)
      alive_cnt_reg <= alive_cnt_reg - 8'h01;

  // ************************************
  // Bus target state machine
  // ************************************
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_PTR = 3'd2;
  localparam ST_WDATA = 3'd3;
  localparam ST_RDATA = 3'd4;
  localparam ST_ACK = 3'd5;
  localparam ST_RACK = 3'd6;

  reg [2:0] state_reg, ret_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg, ptr_reg;
  reg [7:0] ctrl_reg, trim_lo_reg, trim_hi_reg;
  reg lost_h_reg;
  reg rd_clear_reg;
  reg [6:0] my_addr;

  // Bus address from the address select pin
  always @*
    case (sel_s2_reg)
      `SEL_GND: my_addr = `ADDR_GND;
      `SEL_VDD: my_addr = `ADDR_VDD;
      default: my_addr = `ADDR_FLOAT;
    endcase

  // Status byte; bit 0 always reads zero
  wire [7:0] status_byte = {st_s2_reg[7], st_s2_reg[6],
    st_s2_reg[5], st_s2_reg[4], st_s2_reg[3],
    ~ld_s_reg[1], lost_h_reg, 1'b0};

  reg [7:0] rd_byte;
  // Read mux; returns zero for offsets outside the register map
  always @*
    case (ptr_reg)
      `REG_INPUT_STATUS: rd_byte = status_byte;
      `REG_DEVICE_CONTROL: rd_byte = ctrl_reg;
      `REG_TRIM_LO: rd_byte = trim_lo_reg;
      `REG_TRIM_HI: rd_byte = trim_hi_reg;
      default: rd_byte = 8'h00;
    endcase

  wire [7:0] shift_in = {shift_reg[6:0], sda};
  reg wr_en;
  reg ptr_phase_reg;

  // Protocol sequencing on sampled bus clock edges
  always @(posedge clock or negedge nrst)
    if (!nrst)
    begin
      state_reg <= ST_IDLE;
      ret_reg <= ST_IDLE;
      bit_cnt_reg <= 4'd0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      sda_oe_n <= 1'b1;
      rd_clear_reg <= 1'b0;
      ptr_phase_reg <= 1'b0;
      wr_en <= 1'b0;
    end
    else
    begin
      wr_en <= 1'b0;
      rd_clear_reg <= 1'b0;
      if (start_cond)
      begin
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'd0;
        sda_oe_n <= 1'b1;
      end
      else if (stop_cond)
      begin
        state_reg <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end
      else
        case (state_reg)
          ST_ADDR, ST_PTR, ST_WDATA:
          begin
            if (scl_rise)
            begin
              shift_reg <= shift_in;
              bit_cnt_reg <= bit_cnt_reg + 4'd1;
            end
            if (scl_fall && bit_cnt_reg == 4'd8)
            begin
              bit_cnt_reg <= 4'd0;
              if (state_reg == ST_ADDR && shift_reg[7:1] != my_addr)
                state_reg <= ST_IDLE;
              else if (state_reg == ST_ADDR && shift_reg[0])
              begin
                // Address byte of a read is acknowledged before data goes out
                sda_oe_n <= 1'b0;
                state_reg <= ST_ACK;
                ret_reg <= ST_RDATA;
              end
              else
              begin
                // Acknowledge even without the reference clock
                sda_oe_n <= 1'b0;
                state_reg <= ST_ACK;
                if (state_reg == ST_ADDR)
                  ret_reg <= ST_PTR;
                else if (state_reg == ST_PTR)
                begin
                  ptr_reg <= shift_reg;
                  ret_reg <= ST_WDATA;
                end
                else
                begin
                  wr_en <= ref_alive;
                  ret_reg <= ST_WDATA;
                end
              end
            end
          end
          ST_ACK:
            if (scl_fall)
            begin
              sda_oe_n <= 1'b1;
              state_reg <= ret_reg;
              if (ret_reg == ST_WDATA && ptr_phase_reg)
                ptr_reg <= ptr_reg + 8'h01;
              if (ret_reg == ST_RDATA)
              begin
                bit_cnt_reg <= 4'd0;
                sda_oe_n <= rd_byte[7];
                shift_reg <= rd_byte;
                rd_clear_reg <= (ptr_reg == `REG_INPUT_STATUS);
              end
            end
          ST_RDATA:
            if (scl_fall)
            begin
              bit_cnt_reg <= bit_cnt_reg + 4'd1;
              if (bit_cnt_reg == 4'd7)
              begin
                sda_oe_n <= 1'b1;
                state_reg <= ST_RACK;
                ptr_reg <= ptr_reg + 8'h01;
              end
              else
              begin
                sda_oe_n <= shift_reg[6];
                shift_reg <= {shift_reg[6:0], 1'b0};
              end
            end
          ST_RACK:
          begin
            if (scl_rise && sda)
              state_reg <= ST_IDLE;
            else if (scl_fall)
            begin
              state_reg <= ST_RDATA;
              bit_cnt_reg <= 4'd0;
              sda_oe_n <= rd_byte[7];
              shift_reg <= rd_byte;
              rd_clear_reg <= (ptr_reg == `REG_INPUT_STATUS);
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      // Pointer moves after each data byte once one is accepted with the reference alive, not the pointer byte itself
      if (wr_en)
        ptr_phase_reg <= 1'b1;
      else if (state_reg != ST_ACK && state_reg != ST_WDATA)
        ptr_phase_reg <= 1'b0;
    end

  // ************************************
  // Writable registers
  // ************************************
  // Status offset has no write path; reserved mode code is not stored
  always @(posedge clock or negedge nrst)
    if (!nrst)
    begin
      ctrl_reg <= `CTRL_RESET;
      trim_lo_reg <= `TRIM_LO_RESET;
      trim_hi_reg <= `TRIM_HI_RESET;
    end
    else if (wr_en)
      case (ptr_reg)
        `REG_DEVICE_CONTROL:
          if (shift_reg[`CTRL_MODE_HI:`CTRL_MODE_LO] != 2'b11)
            ctrl_reg <= {1'b0, shift_reg[6:0]};
        `REG_TRIM_LO: trim_lo_reg <= shift_reg;
        `REG_TRIM_HI: trim_hi_reg <= shift_reg;
        default: ctrl_reg <= ctrl_reg;
      endcase

  // Lost-hsync flag: a new event beats the read clear
  always @(posedge clock or negedge nrst)
    if (!nrst)
      lost_h_reg <= 1'b0;
    else if (st_s2_reg[2] && !st_s2_reg[4])
      lost_h_reg <= 1'b1;
    else if (rd_clear_reg)
      lost_h_reg <= 1'b0;

  // ************************************
  // Primary loop control
  // ************************************
  wire [1:0] mode = ctrl_reg[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire ref_lost = ld_s_reg[1];
  // Shift keeps the trim pair at the top of a wider level without a zero replication
  wire [CTRL_W-1:0] trim_level = {trim_hi_reg, trim_lo_reg} << (CTRL_W - 16);
  reg [CTRL_W-1:0] held_level_reg;

  // The phase error only steers the level in genlock with a valid reference
  always @(posedge clock or negedge nrst)
    if (!nrst)
    begin
      osc_level <= {CTRL_W{1'b0}};
      held_level_reg <= {CTRL_W{1'b0}};
      primary_loop_mode <= `MODE_GENLOCK;
      ref_loss_fallback <= 1'b0;
      holdover_active <= 1'b0;
      secondary_follow <= 1'b1;
    end
    else
    begin
      primary_loop_mode <= mode;
      ref_loss_fallback <= ctrl_reg[`CTRL_FALLBACK];
      secondary_follow <= 1'b1;
      holdover_active <= 1'b0;
      if (mode == `MODE_FREE_RUN || (mode == `MODE_GENLOCK && ref_lost &&
        ctrl_reg[`CTRL_FALLBACK]))
        osc_level <= trim_level;
      else if (mode == `MODE_HOLDOVER || (mode == `MODE_GENLOCK && ref_lost))
      begin
        osc_level <= held_level_reg;
        holdover_active <= 1'b1;
      end
      else
      begin
        osc_level <= osc_level + loop_error;
        held_level_reg <= osc_level;
      end
    end

endmodule

//--- verif/config_port_asserts.sv
// Concurrent checks on the configuration port pins
`timescale 1ns/1ps
module config_port_asserts #(
  parameter CTRL_W = 16
)(
  input logic clock, // System clock
  input logic nrst, // Reset, active low
  input logic scl_in, // Bus clock pin
  input logic sda_oe_n, // Data pull, active low
  input logic ref_loss_pin, // Reference lost
  input logic [CTRL_W-1:0] loop_error, // Phase error
  input logic [CTRL_W-1:0] osc_level, // Control level
  input logic [1:0] primary_loop_mode, // Mode field
  input logic ref_loss_fallback, // Fallback bit
  input logic holdover_active, // Held level in use
  input logic secondary_follow // Secondary loops track
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // *****
  // Bus pin and loop mode checks
  // *****
  // Data may only move while the bus clock is low, else it forms a false start or stop
  a_ack_pull_low: assert property ($fell(sda_oe_n) |-> !scl_in)
    else $error("data pulled while bus clock high");
  a_data_release_low: assert property ($rose(sda_oe_n) |-> !scl_in)
    else $error("data released while bus clock high");
  a_mode_legal: assert property (primary_loop_mode != 2'h3)
    else $error("reserved mode code stored");
  a_follow_always: assert property (secondary_follow)
    else $error("secondary loops not following");
  a_freerun_no_hold: assert property (primary_loop_mode == 2'h0 |-> !holdover_active)
    else $error("held level used in free-run");
  a_forced_hold: assert property ((primary_loop_mode == 2'h2)[*3] |-> holdover_active)
    else $error("forced holdover not active");
  a_hold_steady: assert property (holdover_active[*3] |-> $stable(osc_level))
    else $error("level moved during holdover");
  // Loss handling waits a few cycles because the loss pin passes a synchroniser
  a_loss_hold: assert property ((primary_loop_mode == 2'h1 && ref_loss_pin &&
    !ref_loss_fallback)[*4] |-> holdover_active)
    else $error("loss with fallback zero not held");
  a_loss_free: assert property ((primary_loop_mode == 2'h1 && ref_loss_pin &&
    ref_loss_fallback)[*4] |-> !holdover_active)
    else $error("loss with fallback one held");
  a_genlock_steer: assert property ((primary_loop_mode == 2'h1 && !ref_loss_pin &&
    loop_error != 0)[*4] |-> osc_level != $past(osc_level))
    else $error("genlock level not steered");
  c_ack_seen: cover property ($fell(sda_oe_n));
  c_free_run: cover property (primary_loop_mode == 2'h0);
  c_loss_held: cover property (holdover_active && primary_loop_mode == 2'h1);
endmodule

//--- verif/i2c_host_model.sv
// Bus controller model for the configuration port's two-wire bus
`timescale 1ns/1ps
module i2c_host_model (
  output logic scl, // Bus clock, stands high outside frames
  output logic sda_rel, // High releases data, low pulls it down
  input wire sda // Resolved data wire
);
  // *****
  // Bus phases, one bit each 320 ns
  // *****
  // Data changes only with the clock low; sampled mid-high
  task bit_io(input logic b, output logic r);
    #80 sda_rel = b;
    #80 scl = 1'b1;
    #80 r = sda;
    #80 scl = 1'b0;
  endtask
  // Start: data falls while clock is high
  task start;
    sda_rel = 1'b1;
    scl = 1'b1;
    #80 sda_rel = 1'b0;
    #80 scl = 1'b0;
  endtask
  // Stop: data rises while clock is high, then the clock stands still
  task stop;
    #80 sda_rel = 1'b0;
    #80 scl = 1'b1;
    #80 sda_rel = 1'b1;
    #80;
  endtask
  // Byte goes MSB first; ack reports a low ninth bit
  task byte_io(input logic [7:0] d, input logic nk, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(nk, r);
    ack = !r;
  endtask
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
endmodule

//--- verif/tb_top.sv
// Testbench for the configuration port: register, status and loop scenarios
`timescale 1ns/1ps
`include "config_port_map.vh"
module tb_top;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] addr_sel = 2'h1;
  logic ref_clk_27 = 1'b0;
  logic ref_run = 1'b1;
  logic [2:0] sync = 3'h0;
  logic ref_loss_pin = 1'b0;
  logic [5:0] det = 6'h00;
  logic [15:0] loop_error = 16'h0003;
  logic [6:0] dev_a = `ADDR_FLOAT;
  logic scl, sda_rel;
  wire sda_oe_n, ref_loss_fallback, holdover_active, secondary_follow;
  wire [15:0] osc_level;
  wire [1:0] primary_loop_mode;
  wire sda_in = sda_oe_n & sda_rel; // Pull-up resolves the open-drain wire
  int fail_count = 0;
  int compares = 0;
  // Clocks; the reference stops on demand to starve internal transfers
  always #20 clock = ~clock;
  always #18.5 ref_clk_27 = ref_run ? ~ref_clk_27 : ref_clk_27;
  // Syncs run only with a valid reference, as a sync separator gate would do
  always #1000 if (!ref_loss_pin) sync = sync + 3'h1;
  i2c_host_model ctl (.scl(scl), .sda_rel(sda_rel), .sda(sda_in));
  config_port uut (
    .clock(clock), .nrst(nrst), .scl_in(scl), .sda_in(sda_in), .sda_oe_n(sda_oe_n),
    .addr_sel(addr_sel), .ref_clk_27(ref_clk_27), .hsync_in(sync[0]),
    .vsync_in(sync[1]), .field_in(sync[2]), .ref_loss_pin(ref_loss_pin),
    .det_interlaced(det[5]), .det_analog(det[4]), .det_polarity(det[3]),
    .det_hdv_warn(det[2]), .det_h_only(det[1]), .hsync_absent(det[0]),
    .loop_error(loop_error), .osc_level(osc_level), .primary_loop_mode(primary_loop_mode),
    .ref_loss_fallback(ref_loss_fallback), .holdover_active(holdover_active),
    .secondary_follow(secondary_follow)
  );
  // *****
  // Access tasks
  // *****
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task pause;
    repeat (4) @(posedge clock);
    #1;
  endtask
  task put(input logic [7:0] d, input logic ack_exp);
    logic [7:0] q;
    logic ack;
    ctl.byte_io(d, 1'b1, q, ack);
    chk(ack, ack_exp);
  endtask
  task wr(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1, input int n);
    ctl.start();
    put({dev_a, 1'b0}, 1'b1);
    put(p, 1'b1);
    put(d0, 1'b1);
    if (n > 1)
      put(d1, 1'b1);
    ctl.stop();
  endtask
  // Pointer-only write and stop, then a two-byte read ending in a refusal
  task rd(input logic [7:0] p, input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] q;
    logic ack;
    ctl.start();
    put({dev_a, 1'b0}, 1'b1);
    put(p, 1'b1);
    ctl.stop();
    ctl.start();
    put({dev_a, 1'b1}, 1'b1);
    ctl.byte_io(8'hFF, 1'b0, q, ack);
    chk(q, e0);
    ctl.byte_io(8'hFF, 1'b1, q, ack);
    chk(q, e1);
    ctl.stop();
  endtask
  task print_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // *****
  // Scenarios
  // *****
  initial
  begin
    repeat (20) @(posedge clock);
    #1 nrst = 1'b1;
    pause();
    chk(primary_loop_mode, `MODE_GENLOCK);
    chk(secondary_follow, 1'b1);
    rd(`REG_DEVICE_CONTROL, `CTRL_RESET, 8'h00);
    rd(`REG_TRIM_LO, `TRIM_LO_RESET, `TRIM_HI_RESET);
    // Every select state against every candidate address
    for (int s = 0; s < 3; s++)
      for (int a = 0; a < 3; a++)
      begin
        addr_sel = s[1:0];
        dev_a = 7'h65 + a[6:0];
        ctl.start();
        put({dev_a, 1'b0}, a == s);
        ctl.stop();
      end
    addr_sel = `SEL_FLOAT;
    dev_a = `ADDR_FLOAT;
    wr(`REG_TRIM_LO, 8'h34, 8'h12, 2);
    wr(`REG_DEVICE_CONTROL, 8'h23, 8'h00, 1);
    pause();
    chk(primary_loop_mode, `MODE_FREE_RUN);
    chk(osc_level, 16'h1234);
    wr(`REG_DEVICE_CONTROL, 8'h33, 8'h00, 1);
    pause();
    chk(holdover_active, 1'b1);
    wr(`REG_DEVICE_CONTROL, 8'h3B, 8'h00, 1);
    pause();
    chk(primary_loop_mode, `MODE_HOLDOVER);
    wr(`REG_DEVICE_CONTROL, 8'h2F, 8'h00, 1);
    pause();
    chk(holdover_active, 1'b0);
    chk(ref_loss_fallback, 1'b1);
    ref_loss_pin = 1'b1;
    pause();
    chk(osc_level, 16'h1234);
    wr(`REG_DEVICE_CONTROL, `CTRL_RESET, 8'h00, 1);
    pause();
    chk(holdover_active, 1'b1);
    det = 6'h2B;
    pause();
    det[0] = 1'b0;
    wr(`REG_INPUT_STATUS, 8'h55, 8'h00, 1);
    rd(`REG_INPUT_STATUS, 8'hAA, 8'h00);
    rd(`REG_INPUT_STATUS, 8'hA8, 8'h00);
    ref_loss_pin = 1'b0;
    det = 6'h15;
    pause();
    det[0] = 1'b0;
    rd(`REG_INPUT_STATUS, 8'h54, 8'h00);
    ref_run = 1'b0;
    repeat (20) @(posedge clock);
    #1;
    wr(`REG_TRIM_LO, 8'h55, 8'h00, 1);
    ref_run = 1'b1;
    repeat (20) @(posedge clock);
    #1;
    rd(`REG_TRIM_LO, 8'h34, 8'h12);
    print_verdict();
  end
  // Watchdog against a hung bus sequence
  initial
  begin
    repeat (100000) @(posedge clock);
    fail_count++;
    print_verdict();
  end
endmodule
bind config_port config_port_asserts #(.CTRL_W(CTRL_W)) chk_i (
  .clock(clock), .nrst(nrst), .scl_in(scl_in), .sda_oe_n(sda_oe_n),
  .ref_loss_pin(ref_loss_pin), .loop_error(loop_error), .osc_level(osc_level),
  .primary_loop_mode(primary_loop_mode), .ref_loss_fallback(ref_loss_fallback),
  .holdover_active(holdover_active), .secondary_follow(secondary_follow)
);
